// ---- bench/nmg_ack_sink.sv ----
// Purpose: System bus end that takes exit acknowledges
// Assumes: Acknowledge is a one-cycle pulse
// Notes:   Counts only; the transaction has no ready to stall
module nmg_ack_sink
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic exit_ack,
   output int        acks
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         acks <= 0;
      else if (exit_ack)
         acks <= acks + 1;
   end
endmodule

// ---- bench/nmg_gate_assertions.sv ----
// Purpose: Timing checks on the gating block
// Assumes: Core events are one-cycle pulses
// Notes:   Bound to every nmg_gate
module nmg_gate_chk
(
   input wire logic                  clk,
   input wire logic                  rstn,
   input wire nmg_pkg::nmg_events_t  events,
   input wire nmg_pkg::nmg_restore_t restore,
   input wire logic                  exit_ack,
   input wire logic                  nmi_take,
   input wire logic                  in_mgmt,
   input wire logic                  nmi_blocked,
   input wire logic                  nmi_pending,
   input wire logic                  resume_done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_block_entry: assert property (!in_mgmt && events.mgmt_int
      |=> in_mgmt && nmi_blocked) else $error("entry not blocked");
   a_latch_req: assert property (nmi_blocked && events.nmi_req
      |=> nmi_pending) else $error("request not latched");
   a_latch_hold: assert property (nmi_pending && nmi_blocked
      && !events.iret_exec |=> nmi_pending) else $error("latch lost");
   a_pend_first: assert property (exit_ack && nmi_pending
      |=> nmi_take && resume_done) else $error("pending not served");
   a_iret_unblock: assert property (nmi_blocked && events.iret_exec
      |=> !nmi_blocked) else $error("return kept block");
   a_free_take: assert property (!nmi_blocked && !nmi_pending
      && events.nmi_req |=> nmi_take) else $error("request not taken");
   a_restore_start: assert property (in_mgmt && events.resume_exec
      |-> ##2 restore.valid && restore.index == 4'h0) else $error("no reload");
   a_restore_step: assert property (restore.valid
      && restore.index != 4'h7 |=> restore.valid
      && restore.index == $past(restore.index) + 4'h1) else $error("reload order");
   a_ack_after: assert property (restore.valid
      && restore.index == 4'h7 |=> exit_ack && !nmi_blocked) else $error("no ack");
   a_pend_clear: assert property (nmi_take && !events.nmi_req
      |=> !nmi_pending) else $error("latch not cleared");
endmodule
bind nmg_gate nmg_gate_chk u_chk (.clk, .rstn, .events, .restore, .exit_ack,
   .nmi_take, .in_mgmt, .nmi_blocked, .nmi_pending, .resume_done);

// ---- bench/nmg_gate_bench.sv ----
// Purpose: Self-checking bench for the gating block
// Assumes: Seed 68, 125 MHz clock
// Notes:   Exact cycle timing is left to the checker
`include "nmg_map.svh"
module nmg_gate_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   clk, rstn, save_wr, exit_ack, nmi_take;
   logic                   in_mgmt, nmi_blocked, nmi_pending, resume_done;
   logic [`NMG_IDX_W-1:0]  save_addr;
   logic [`NMG_WORD_W-1:0] save_data;
   logic [`NMG_WORD_W-1:0] img [8];
   nmg_pkg::nmg_events_t   events;
   nmg_pkg::nmg_restore_t  restore;
   int                     err_total, cmp_count, takes, acks, n, dones;
   bit                     iret;
   always #4 clk = ~clk;
   nmg_gate dut (.clk, .rstn, .events, .save_wr, .save_addr, .save_data,
      .restore, .exit_ack, .nmi_take, .in_mgmt, .nmi_blocked, .nmi_pending,
      .resume_done);
   nmg_ack_sink sink (.clk, .rstn, .exit_ack, .acks);
   function automatic int exp_take(int cnt, bit ret);
      // Without a return only one request survives the handler
      return ret ? cnt : int'(cnt > 0);
   endfunction
   task automatic chk(string what, logic [36:0] seen, logic [36:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic pulse(nmg_pkg::nmg_events_t e);
      events <= e;
      @(posedge clk);
      events <= '0;
      @(posedge clk);
   endtask
   task automatic summarize;
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      if (nmi_take === 1'b1)
         takes++;
      if (resume_done === 1'b1)
         dones++;
      if (restore.valid === 1'b1)
         chk("restore", restore.data, img[restore.index]);
   end
   initial
   begin
      #50000;
      err_total++;
      summarize;
   end
   initial
   begin
      clk = 0;
      rstn = 0;
      events = '0;
      save_wr = 0;
      save_addr = '0;
      save_data = '0;
      void'($urandom(68));
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      chk("idle", {in_mgmt, nmi_blocked, nmi_pending}, '0);
      for (int k = 0; k < 8; k++)
      begin
         img[k] = $urandom;
         save_wr <= 1'b1;
         save_addr <= k[3:0];
         save_data <= img[k];
         @(posedge clk);
      end
      save_wr <= 1'b0;
      for (int ep = 1; ep <= 8; ep++)
      begin
         n = (ep < 3) ? 3 : $urandom_range(0, 3);
         iret = (ep == 2) || (ep > 2 && $urandom_range(0, 1) == 1);
         @(posedge clk);
         takes = 0;
         pulse(4'h8);
         if (iret)
            pulse(4'h2);
         for (int j = 0; j < n; j++)
            pulse(4'h1);
         @(negedge clk);
         chk("held", takes, iret ? n : 0);
         chk("blocked", nmi_blocked, !iret);
         chk("pending", nmi_pending, n > 0 && !iret);
         @(posedge clk);
         pulse(4'h4);
         repeat (14) @(posedge clk);
         @(negedge clk);
         chk("taken", takes, exp_take(n, iret));
         chk("acks", acks, ep);
         chk("dones", dones, ep);
         chk("left", {in_mgmt, nmi_blocked, nmi_pending}, '0);
         @(posedge clk);
         pulse(4'h1);
         @(negedge clk);
         chk("free", takes, exp_take(n, iret) + 1);
      end
      summarize;
   end
endmodule

// ---- hdl/nmg_gate.sv ----
// Purpose: Non-maskable interrupt gating around management mode
// Assumes: Core clk 125 MHz; event inputs are one-cycle pulses from core
// Notes:   Save image is written by the core through save_* ports
// Behaviour
// - Delivery of non-maskable requests is blocked from handler entry.
// - A request blocked during the handler is latched and served after exit.
// - The latch holds one request; extra ones are dropped.
// - A latched request is served before the interrupted code resumes.
// - An interrupt return inside the handler lifts the blocking.
// - Resume reloads registers from the saved state image.
// - After the reload an exit acknowledge goes out on the system bus.
`include "nmg_map.svh"
module nmg_gate
(
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire nmg_pkg::nmg_events_t   events,
   input  wire logic                   save_wr,
   input  wire logic [`NMG_IDX_W-1:0]  save_addr,
   input  wire logic [`NMG_WORD_W-1:0] save_data,
   output nmg_pkg::nmg_restore_t       restore,
   output logic                        exit_ack,
   output logic                        nmi_take,
   output logic                        in_mgmt,
   output logic                        nmi_blocked,
   output logic                        nmi_pending,
   output logic                        resume_done
);
   logic                  rst_s1_reg;
   logic                  rst_s2_reg;
   nmg_pkg::nmg_state_t   state_reg;
   nmg_pkg::nmg_state_t   state_next;
   logic                  block_reg;
   logic                  block_next;
   logic                  pend_reg;
   logic                  pend_next;
   logic [`NMG_IDX_W-1:0] idx_reg;
   logic [`NMG_IDX_W-1:0] idx_next;
   logic                  rvalid_reg;
   logic                  rvalid_next;
   logic [`NMG_IDX_W-1:0] ridx_reg;
   logic [`NMG_IDX_W-1:0] ridx_next;
   logic                  ack_reg;
   logic                  ack_next;
   logic                  take_reg;
   logic                  take_next;
   logic                  done_reg;
   logic                  done_next;
   logic [`NMG_WORD_W-1:0] rd_data;
   logic                  rst_n;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   assign rst_n = rst_s2_reg;

   // Request that meets no block is delivered at once
   function automatic logic req_free
   (
      input nmg_pkg::nmg_events_t ev,
      input logic                 blocked
   );
      return ev.nmi_req && !blocked;
   endfunction

   // Image is not reset; the core writes it before any resume
   nmg_save_mem u_mem
   (
      .clk     (clk),
      .wr_en   (save_wr),
      .wr_addr (save_addr),
      .wr_data (save_data),
      .rd_addr (idx_reg),
      .rd_data (rd_data)
   );

   always_comb
   begin
      state_next  = state_reg;
      block_next  = block_reg;
      pend_next   = pend_reg;
      idx_next    = idx_reg;
      rvalid_next = 1'b0;
      ridx_next   = idx_reg;
      ack_next    = 1'b0;
      take_next   = 1'b0;
      done_next   = 1'b0;
      unique case (state_reg)
         nmg_pkg::NMG_NORMAL:
         begin
            // Same-edge request is taken; the block starts after it
            if (events.nmi_req)
            begin
               take_next = 1'b1;
            end
            if (events.mgmt_int)
            begin
               state_next = nmg_pkg::NMG_HANDLER;
               block_next = 1'b1;
            end
         end
         nmg_pkg::NMG_HANDLER:
         begin
            if (events.iret_exec)
            begin
               block_next = 1'b0;
            end
            if (req_free(events, block_reg))
            begin
               take_next = 1'b1;
               pend_next = 1'b0;
            end
            else if (events.nmi_req)
            begin
               pend_next = 1'b1;
            end
            if (events.resume_exec)
            begin
               state_next = nmg_pkg::NMG_RESTORE;
               idx_next   = 4'h0;
            end
         end
         nmg_pkg::NMG_RESTORE:
         begin
            // Read data lags address by one cycle
            rvalid_next = 1'b1;
            idx_next    = idx_reg + 4'h1;
            // Once unblocked, the reload does not hold requests back
            if (req_free(events, block_reg))
            begin
               take_next = 1'b1;
               pend_next = 1'b0;
            end
            else if (events.nmi_req)
            begin
               pend_next = 1'b1;
            end
            if (idx_reg == `NMG_RESTORE_WORDS - 4'h1)
            begin
               state_next = nmg_pkg::NMG_ACK;
            end
         end
         nmg_pkg::NMG_ACK:
         begin
            ack_next   = 1'b1;
            block_next = 1'b0;
            state_next = nmg_pkg::NMG_RESUME;
            // Blocked requests wait for the resume step
            if (req_free(events, block_reg))
            begin
               take_next = 1'b1;
               pend_next = 1'b0;
            end
            else if (events.nmi_req)
            begin
               pend_next = 1'b1;
            end
         end
         nmg_pkg::NMG_RESUME:
         begin
            // Pending request served before code resumes
            if (pend_reg || events.nmi_req)
            begin
               take_next = 1'b1;
               pend_next = 1'b0;
            end
            done_next  = 1'b1;
            state_next = nmg_pkg::NMG_NORMAL;
         end
         default:
         begin
            state_next = nmg_pkg::NMG_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg  <= nmg_pkg::NMG_NORMAL;
         block_reg  <= 1'b0;
         pend_reg   <= 1'b0;
         idx_reg    <= 4'h0;
         rvalid_reg <= 1'b0;
         ridx_reg   <= 4'h0;
         ack_reg    <= 1'b0;
         take_reg   <= 1'b0;
         done_reg   <= 1'b0;
      end
      else
      begin
         state_reg  <= state_next;
         block_reg  <= block_next;
         pend_reg   <= pend_next;
         idx_reg    <= idx_next;
         rvalid_reg <= rvalid_next;
         ridx_reg   <= ridx_next;
         ack_reg    <= ack_next;
         take_reg   <= take_next;
         done_reg   <= done_next;
      end
   end

   // One driver for the whole struct
   assign restore       = {rvalid_reg, ridx_reg, rd_data};
   assign exit_ack      = ack_reg;
   assign nmi_take      = take_reg;
   assign nmi_blocked   = block_reg;
   assign nmi_pending   = pend_reg;
   assign resume_done   = done_reg;
   assign in_mgmt       = (state_reg != nmg_pkg::NMG_NORMAL);
endmodule

// ---- hdl/nmg_map.svh ----
// Purpose: Constants for the management-mode interrupt gating block
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef NMG_MAP_SVH
`define NMG_MAP_SVH
`define NMG_RESTORE_WORDS  4'h8
`define NMG_WORD_W         32
`define NMG_IDX_W          4
`define NMG_ACK_HOLD       1'b0
`endif

// ---- hdl/nmg_pkg.sv ----
// Purpose: Types for the management-mode interrupt gating block
// Assumes: Constants come from nmg_map.svh
// Notes:   No imports anywhere; uses are scoped
`include "nmg_map.svh"
package nmg_pkg;
   typedef enum logic [2:0]
   {
      NMG_NORMAL  = 3'b000,
      NMG_HANDLER = 3'b001,
      NMG_RESTORE = 3'b010,
      NMG_ACK     = 3'b011,
      NMG_RESUME  = 3'b100
   } nmg_state_t;

   typedef struct packed
   {
      logic mgmt_int;
      logic resume_exec;
      logic iret_exec;
      logic nmi_req;
   } nmg_events_t;

   typedef struct packed
   {
      logic                    valid;
      logic [`NMG_IDX_W-1:0]   index;
      logic [`NMG_WORD_W-1:0]  data;
   } nmg_restore_t;
endpackage

// ---- hdl/nmg_save_mem.sv ----
// Purpose: Management save memory holding the saved state image
// Assumes: Single clock, synchronous write, registered read
// Notes:   Contents are not reset; image is written on entry
`include "nmg_map.svh"
module nmg_save_mem
(
   input  wire logic                   clk,
   input  wire logic                   wr_en,
   input  wire logic [`NMG_IDX_W-1:0]  wr_addr,
   input  wire logic [`NMG_WORD_W-1:0] wr_data,
   input  wire logic [`NMG_IDX_W-1:0]  rd_addr,
   output logic      [`NMG_WORD_W-1:0] rd_data
);
   logic [`NMG_WORD_W-1:0] mem [0:(1<<`NMG_IDX_W)-1];
   logic [`NMG_WORD_W-1:0] rd_data_next;

   always_comb
   begin
      rd_data_next = mem[rd_addr];
   end

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= rd_data_next;
   end
endmodule
